// >>> verilog/tpl1_tx_port.sv
/*
 * transmit serial port layer 1 control for one port: ahb-lite register
 * slave, frame counter with alignment-change detection, transmit data
 * selection and indirect access to the per-ds0 configuration store.
 * assumes the link clock and frame sync arrive asynchronously from the
 * framer and are much slower than hclk; data sources sit on hclk.
 */
`timescale 1ns/100ps
// Contract
// - force-ones bit low drives all ones
// - sync offset code sets expected sync position
// - clear-channel mode ignores offset and frame mode
// - frame mode selects 193/256/512/1024 clocks
// - fast bypass routes clock, data on ports 0-2
// - clear-channel mode overrides slot enables
// - pattern source picks bert or hdlc, clear-channel
// - mask bit gates alignment-change interrupt
// - sync off expected position flags alignment change
// - change flag latches, clears on read
// - per-port store of 384 16-bit entries
// - seven-bit slot index, 0 to 127
// - usable slot range follows port mode
// - two-bit target: data, rx, tx, illegal
// - select write starts access, direction bit picks read or write, busy until done
// - data register holds word moved to store
module tpl1_tx_port
  import tpl1_pkg::*;
#(
  parameter int unsigned PORT_NUM = 0
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // serial link pins
  input  wire logic        tx_serial_clock_pin,
  input  wire logic        tx_frame_sync_pin,
  input  wire logic        rx_line_data_pin,
  output logic             tx_serial_data_pin,
  // transmit data sources
  input  wire logic        hdlc_tx_data,
  input  wire logic        bert_tx_data,
  input  wire logic        fast_tx_data,
  output logic             hdlc_bit_take,
  output logic      [7:0]  hdlc_channel,
  output logic             bert_bit_take,
  output logic             fast_tx_clk,
  // alignment-change interrupt
  output logic             tx_align_irq
);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // bit 8 exists only on the fast-engine ports
  localparam logic [15:0] CTRL_MASK = (PORT_NUM < TPL1_FAST_PORTS) ?
                                      (TPL1_CTRL_WR_MASK | TPL1_CTRL_BYPASS_MSK) : TPL1_CTRL_WR_MASK;

  function automatic logic [9:0] frame_last(input logic [1:0] mode);
    unique case (tpl1_frame_mode_t'(mode))
      TPL1_FM_T1: frame_last = TPL1_LAST_T1;
      TPL1_FM_E1: frame_last = TPL1_LAST_E1;
      TPL1_FM_4M: frame_last = TPL1_LAST_4M;
      TPL1_FM_8M: frame_last = TPL1_LAST_8M;
    endcase
  endfunction : frame_last

  function automatic logic [6:0] slot_top(input logic [1:0] mode, input logic unch);
    logic [6:0] top;
    top = TPL1_TOP_8M;
    unique case (tpl1_frame_mode_t'(mode))
      TPL1_FM_T1: top = TPL1_TOP_T1;
      TPL1_FM_E1: top = TPL1_TOP_E1;
      TPL1_FM_4M: top = TPL1_TOP_4M;
      TPL1_FM_8M: top = TPL1_TOP_8M;
    endcase
    slot_top = unch ? TPL1_SLOT_RESET : top;
  endfunction : slot_top

  // t1 spends bit 0 on the framing bit, so its slots start one bit later
  function automatic logic [6:0] slot_of(input logic [9:0] cnt, input logic [1:0] mode,
                                         input logic unch);
    logic [9:0] pos;
    pos = (tpl1_frame_mode_t'(mode) == TPL1_FM_T1) ? cnt - 10'd1 : cnt;
    slot_of = unch ? TPL1_SLOT_RESET : pos[9:3];
  endfunction : slot_of

  // ---------------------------------------------------------------- bus
  logic        dph_wr_q;
  logic        rd_wait_q;
  logic [7:0]  dph_addr_q;
  logic [31:0] hrdata_q;
  logic [15:0] ctrl_q;
  logic        flag_q;
  logic [6:0]  slot_q;
  logic [1:0]  target_q;
  logic        dir_q;
  logic [15:0] data_q;
  tpl1_ind_state_t ind_q;

  wire        addr_ok  = hsel & htrans[1] & hready;
  wire        wr_ctrl  = dph_wr_q & (dph_addr_q == TPL1_OFS_CTRL);
  wire        wr_sel   = dph_wr_q & (dph_addr_q == TPL1_OFS_SEL);
  wire        wr_data  = dph_wr_q & (dph_addr_q == TPL1_OFS_DATA);
  wire        rd_clear = rd_wait_q & (dph_addr_q == TPL1_OFS_CTRL);
  wire        busy     = (ind_q == TPL1_IND_BUSY);
  wire [15:0] ctrl_rd  = {flag_q, ctrl_q[14:0]};
  wire [15:0] sel_rd   = {busy, dir_q, 4'h0, target_q, 1'b0, slot_q};
  wire [31:0] rd_mux   = (dph_addr_q == TPL1_OFS_CTRL) ? {16'h0000, ctrl_rd} :
                         (dph_addr_q == TPL1_OFS_SEL)  ? {16'h0000, sel_rd}  :
                         (dph_addr_q == TPL1_OFS_DATA) ? {16'h0000, data_q}  : 32'h0000_0000;

  // reads take one wait state so a write just before is already visible
  assign hreadyout = ~rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // address phase capture, whole-word transfers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q   <= 1'b0;
      rd_wait_q  <= 1'b0;
      dph_addr_q <= 8'h00;
    end else begin
      dph_wr_q   <= addr_ok & hwrite;
      rd_wait_q  <= addr_ok & ~hwrite;
      dph_addr_q <= addr_ok ? haddr[7:0] : dph_addr_q;
    end
  end

  // read data is registered in the wait state; unmapped offsets read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_wait_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // control register, read-only flag bit 15 and unassigned bits 12-13 never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= TPL1_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[15:0] & CTRL_MASK;
    end
  end

  // ------------------------------------------------------ indirect access
  wire        unch      = ctrl_q[TPL1_CLEAR_MODE];
  wire [1:0]  mode      = ctrl_q[TPL1_FRAME_MODE_LO +: 2];
  wire        start     = wr_sel & ~busy;
  wire        ind_ok    = (tpl1_ram_target_t'(target_q) != TPL1_TGT_ILLEGAL) &
                          (slot_q <= slot_top(mode, unch));
  wire        ram_we    = busy & ind_ok & ~dir_q;
  wire [8:0]  host_addr = {target_q, slot_q};
  wire [15:0] host_rdata;
  wire [15:0] eng_rdata;
  wire [9:0]  nxt;
  wire [8:0]  eng_addr  = {TPL1_TGT_TX_CFG, slot_of(nxt, mode, unch)};

  // a select write while busy is dropped so the pending access stays intact
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_q   <= TPL1_SLOT_RESET;
      target_q <= TPL1_TGT_DATA;
      dir_q    <= 1'b0;
    end else if (start) begin
      slot_q   <= hwdata[TPL1_SLOT_LO +: 7];
      target_q <= hwdata[TPL1_TARGET_LO +: 2];
      dir_q    <= hwdata[TPL1_DIRECTION];
    end
  end

  // busy lasts exactly one cycle after the select write lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind_q <= TPL1_IND_IDLE;
    end else begin
      unique case (ind_q)
        TPL1_IND_IDLE: ind_q <= start ? TPL1_IND_BUSY : TPL1_IND_IDLE;
        TPL1_IND_BUSY: ind_q <= TPL1_IND_IDLE;
      endcase
    end
  end

  // data register: host writes when idle, store reads land at the end of busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_q <= TPL1_DATA_RESET;
    end else if (busy & ind_ok & dir_q) begin
      data_q <= host_rdata;
    end else if (wr_data & ~busy) begin
      data_q <= hwdata[15:0];
    end
  end

  tpl1_port_ram u_ram (
    .clk        (hclk),
    .wr_en      (ram_we),
    .wr_addr    (host_addr),
    .wr_data    (data_q),
    .host_raddr (host_addr),
    .host_rdata (host_rdata),
    .eng_raddr  (eng_addr),
    .eng_rdata  (eng_rdata)
  );

  // --------------------------------------------------------- link inputs
  logic lclk_s1, lclk_s2, lclk_s3;
  logic sync_s1, sync_s2, sync_prev_q;
  logic rxd_s1, rxd_s2;

  // two-stage synchronisers; the third clock stage only feeds edge detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {lclk_s1, lclk_s2, lclk_s3} <= 3'h0;
      {sync_s1, sync_s2}          <= 2'h0;
      {rxd_s1, rxd_s2}            <= 2'h0;
    end else begin
      {lclk_s1, lclk_s2, lclk_s3} <= {tx_serial_clock_pin, lclk_s1, lclk_s2};
      {sync_s1, sync_s2}          <= {tx_frame_sync_pin, sync_s1};
      {rxd_s1, rxd_s2}            <= {rx_line_data_pin, rxd_s1};
    end
  end

  // ------------------------------------------------------ frame counter
  logic [9:0] cnt_q;

  wire            rise     = lclk_s2 & ~lclk_s3;
  wire            fall     = ~lclk_s2 & lclk_s3;
  wire            bypass   = ctrl_q[TPL1_BYPASS];
  wire            net_loop = ctrl_q[TPL1_NET_LOOP] & unch;
  wire            force_n  = ctrl_q[TPL1_FORCE_ONES_N];
  wire            pat_src  = ctrl_q[TPL1_PATTERN_SRC];
  wire [9:0]      last     = frame_last(mode);
  tpl1_sync_ofs_t ofs;
  assign ofs = tpl1_sync_ofs_t'(ctrl_q[TPL1_SYNC_OFS_LO +: 2]);
  assign nxt = (cnt_q >= last) ? 10'd0 : cnt_q + 10'd1;

  // a half-clock-early sync is caught on the falling edge inside the last bit
  wire       sync_edge = (ofs == TPL1_OFS_HALF) ? fall : rise;
  wire       sync_evt  = ~unch & ~bypass & sync_edge & sync_s2 & ~sync_prev_q;
  wire [9:0] expect_at = (ofs == TPL1_OFS_ZERO) ? 10'd0 :
                         (ofs == TPL1_OFS_TWO)  ? last - 10'd1 : last;
  wire [9:0] seen_at   = (ofs == TPL1_OFS_HALF) ? cnt_q : nxt;
  wire       frame_alignment_change      = sync_evt & (seen_at != expect_at);

  // sync level remembered at each sampling edge only; a sync launched on the
  // other link edge would otherwise be swallowed before it could be seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_prev_q <= 1'b0;
    end else if (sync_edge) begin
      sync_prev_q <= sync_s2;
    end
  end

  // counter realigns to the sync so one change raises one flag, not a stream
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 10'd0;
    end else if (sync_evt) begin
      cnt_q <= expect_at;
    end else if (rise) begin
      cnt_q <= nxt;
    end
  end

  // set wins over a read clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= frame_alignment_change | (flag_q & ~rd_clear);
    end
  end

  assign tx_align_irq = flag_q & ctrl_q[TPL1_IRQ_MASK];

  // ------------------------------------------------------ data selection
  logic       txd_q;
  logic       hdlc_take_q;
  logic       bert_take_q;
  logic [7:0] chan_q;
  logic       fast_clk_q;

  wire fbit     = ~unch & (tpl1_frame_mode_t'(mode) == TPL1_FM_T1) & (nxt == 10'd0);
  wire slot_en  = unch | (eng_rdata[TPL1_CFG_SLOT_EN] & ~fbit);
  wire use_bert = unch ? pat_src : eng_rdata[TPL1_CFG_PATTERN];
  wire normal   = ~bypass & ~net_loop & slot_en;
  wire line_bit = bypass   ? fast_tx_data :
                  net_loop ? rxd_s2 :
                  ~slot_en ? 1'b1 :
                  use_bert ? bert_tx_data : hdlc_tx_data;
  // idle slots and the t1 framing bit go out as ones

  // a new bit leaves on each rising link edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_q       <= 1'b1;
      hdlc_take_q <= 1'b0;
      bert_take_q <= 1'b0;
      chan_q      <= 8'h00;
      fast_clk_q  <= 1'b0;
    end else begin
      fast_clk_q  <= bypass & lclk_s2;
      hdlc_take_q <= rise & normal & ~use_bert;
      bert_take_q <= rise & normal & use_bert;
      if (rise) begin
        txd_q  <= ~force_n | line_bit;
        chan_q <= eng_rdata[7:0];
      end
    end
  end

  assign tx_serial_data_pin = txd_q;
  assign hdlc_bit_take      = hdlc_take_q;
  assign bert_bit_take      = bert_take_q;
  assign hdlc_channel       = chan_q;
  assign fast_tx_clk        = fast_clk_q;

  // ---------------------------------------------------------- assertions
  sequence ind_start_s;
    start;
  endsequence
  sequence ind_done_s;
    busy ##1 !busy;
  endsequence

  force_ones_a : assert property ((rise && !force_n) |=> tx_serial_data_pin)
    else $error("force ones not applied");
  fast_bypass_a : assert property ((rise && bypass && force_n) |=>
                                   tx_serial_data_pin == $past(fast_tx_data))
    else $error("fast bypass data wrong");
  clear_hdlc_a : assert property ((rise && unch && !bypass && !net_loop && force_n && !pat_src) |=>
                                  tx_serial_data_pin == $past(hdlc_tx_data))
    else $error("clear channel hdlc data wrong");
  clear_bert_a : assert property ((rise && unch && !bypass && !net_loop && force_n && pat_src) |=>
                                  tx_serial_data_pin == $past(bert_tx_data))
    else $error("clear channel bert data wrong");
  clear_no_flag_a : assert property (unch |-> !frame_alignment_change)
    else $error("alignment change in clear channel mode");
  align_flag_a : assert property (frame_alignment_change |=> flag_q ##0 (tx_align_irq == ctrl_q[TPL1_IRQ_MASK]))
    else $error("alignment change not flagged");
  irq_mask_a : assert property (!ctrl_q[TPL1_IRQ_MASK] |-> !tx_align_irq)
    else $error("masked interrupt raised");
  flag_clear_a : assert property ((rd_clear && !frame_alignment_change) |=> !flag_q)
    else $error("flag not cleared by read");
  flag_hold_a : assert property ((flag_q && !rd_clear) |=> flag_q)
    else $error("flag lost without read");
  ind_busy_a : assert property (ind_start_s |=> ind_done_s)
    else $error("busy not one cycle");
  slot_range_a : assert property (ram_we |-> (slot_q <= slot_top(mode, unch)) &&
                                  (target_q != TPL1_TGT_ILLEGAL))
    else $error("store written out of range");

endmodule : tpl1_tx_port

// >>> verilog/tpl1_pkg.sv
/*
 * constants, field positions and types shared by the transmit port layer 1
 * control block and its per-ds0 configuration store.
 * assumes a 100 MHz bus clock and one 32-bit ahb-lite word per register.
 */
package tpl1_pkg;

  // register byte offsets
  localparam logic [7:0]  TPL1_OFS_CTRL        = 8'h00;
  localparam logic [7:0]  TPL1_OFS_SEL         = 8'h04;
  localparam logic [7:0]  TPL1_OFS_DATA        = 8'h08;

  // tx_port_control fields
  localparam int          TPL1_FORCE_ONES_N    = 3;
  localparam int          TPL1_SYNC_OFS_LO     = 4;
  localparam int          TPL1_FRAME_MODE_LO   = 6;
  localparam int          TPL1_BYPASS          = 8;
  localparam int          TPL1_CLEAR_MODE      = 9;
  localparam int          TPL1_NET_LOOP        = 10;
  localparam int          TPL1_PATTERN_SRC     = 11;
  localparam int          TPL1_IRQ_MASK        = 14;
  localparam int          TPL1_ALIGN_FLAG      = 15;
  localparam logic [15:0] TPL1_CTRL_RESET      = 16'h0000;
  localparam logic [15:0] TPL1_CTRL_WR_MASK    = 16'h4eff;
  localparam logic [15:0] TPL1_CTRL_BYPASS_MSK = 16'h0100;
  localparam int          TPL1_FAST_PORTS      = 3;

  // port_ram_indirect_select fields
  localparam int          TPL1_SLOT_LO         = 0;
  localparam int          TPL1_TARGET_LO       = 8;
  localparam int          TPL1_DIRECTION       = 14;
  localparam int          TPL1_BUSY            = 15;
  localparam logic [6:0]  TPL1_SLOT_RESET      = 7'h00;
  localparam logic [15:0] TPL1_DATA_RESET      = 16'h0000;

  // ds0_tx_config fields
  localparam int          TPL1_CFG_SLOT_EN     = 15;
  localparam int          TPL1_CFG_PATTERN     = 14;

  // store geometry: three entries of 16 bits for each of 128 slots
  localparam int          TPL1_SLOTS           = 128;
  localparam int          TPL1_RAM_DEPTH       = 384;

  // last bit index of each frame and highest usable slot per mode
  localparam logic [9:0]  TPL1_LAST_T1         = 10'd192;
  localparam logic [9:0]  TPL1_LAST_E1         = 10'd255;
  localparam logic [9:0]  TPL1_LAST_4M         = 10'd511;
  localparam logic [9:0]  TPL1_LAST_8M         = 10'd1023;
  localparam logic [6:0]  TPL1_TOP_T1          = 7'd23;
  localparam logic [6:0]  TPL1_TOP_E1          = 7'd31;
  localparam logic [6:0]  TPL1_TOP_4M          = 7'd63;
  localparam logic [6:0]  TPL1_TOP_8M          = 7'd127;

  typedef enum logic [1:0] {
    TPL1_FM_T1 = 2'h0,
    TPL1_FM_E1 = 2'h1,
    TPL1_FM_4M = 2'h2,
    TPL1_FM_8M = 2'h3
  } tpl1_frame_mode_t;

  typedef enum logic [1:0] {
    TPL1_OFS_ZERO = 2'h0,
    TPL1_OFS_HALF = 2'h1,
    TPL1_OFS_ONE  = 2'h2,
    TPL1_OFS_TWO  = 2'h3
  } tpl1_sync_ofs_t;

  typedef enum logic [1:0] {
    TPL1_TGT_DATA    = 2'h0,
    TPL1_TGT_RX_CFG  = 2'h1,
    TPL1_TGT_TX_CFG  = 2'h2,
    TPL1_TGT_ILLEGAL = 2'h3
  } tpl1_ram_target_t;

  typedef enum logic [1:0] {
    TPL1_IND_IDLE = 2'b01,
    TPL1_IND_BUSY = 2'b10
  } tpl1_ind_state_t;

endpackage : tpl1_pkg

// >>> verilog/tpl1_port_ram.sv
/*
 * per-port store of 384 16-bit entries, flip-flops addressed by index.
 * assumes one synchronous write port and two combinational read ports,
 * all on the bus clock; contents are not reset.
 */
`timescale 1ns/100ps
module tpl1_port_ram
  import tpl1_pkg::*;
(
  // clock
  input  wire logic        clk,
  // host write port
  input  wire logic        wr_en,
  input  wire logic [8:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  // host read port
  input  wire logic [8:0]  host_raddr,
  output logic      [15:0] host_rdata,
  // layer 1 engine read port
  input  wire logic [8:0]  eng_raddr,
  output logic      [15:0] eng_rdata
);

  logic [15:0] mem_q [TPL1_RAM_DEPTH];

  // no reset: software loads every entry it uses after power-up
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // out-of-range indexes reach the host read port only; callers limit the target code on writes
  assign host_rdata = mem_q[host_raddr];
  assign eng_rdata  = mem_q[eng_raddr];

endmodule : tpl1_port_ram

// >>> tb/tpl1_framer_model.sv
/*
 * behavioural framer serial port: link clock, frame sync and line data.
 * assumes the bench sets frame length, sync bit position and line level.
 */
`timescale 1ns/100ps
module tpl1_framer_model (
  // control from the bench
  input  wire logic        run,
  input  wire logic [10:0] frame_len,
  input  wire logic [10:0] sync_bit,
  input  wire logic        line_val,
  // link pins
  output logic             link_clk,
  output logic             frame_sync,
  output logic             line_data
);
  int cnt;

  // 8 MHz link, below the net loop speed limit; clock stands still while run is low
  initial begin
    link_clk = 1'b0;
    frame_sync = 1'b0;
    line_data = 1'b0;
    cnt = 0;
    forever begin
      if (run) begin
        frame_sync = (cnt == sync_bit);
        line_data  = line_val;
        #62.5 link_clk = 1'b1;
        #62.5 link_clk = 1'b0;
        cnt = (cnt + 1) % frame_len;
      end else begin
        frame_sync = 1'b0;
        line_data  = ~line_data; // idle line must not look like held data
        cnt = 0;
        #10;
      end
    end
  end
endmodule : tpl1_framer_model

// >>> tb/tb_tpl1_tx_port.sv
/*
 * self-checking bench for the transmit port layer 1 control block, port 0.
 * assumes an ahb-lite master made of tasks and a framer model on the link.
 */
`timescale 1ns/100ps
module tb_tpl1_tx_port
  import tpl1_pkg::*;
;
  // bus, pins and bench state
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        link_clk, frame_sync, line_data, tx_data, align_irq;
  logic        hdlc_d, bert_d, fast_d, run, line_val;
  logic        hdlc_take, bert_take, fast_clk;
  logic [7:0]  hdlc_ch;
  logic [2:0]  seen;
  logic [10:0] frame_len, sync_bit;
  logic [15:0] rd;
  int          bad_count, comparisons;
  // source rows: hdlc, bert, fast, line level, expected bit, hdlc take, bert take, fast clock
  logic [15:0] ctl_tab [6] = '{16'h0200, 16'h0208, 16'h0a08, 16'h0608, 16'h0308, 16'h0a00};
  logic [7:0]  src_tab [6] = '{8'h7c, 8'h74, 8'h4a, 8'he0, 8'hd1, 8'h0a};
  // frame rows: control, frame length, sync bit (last three rows use early offsets)
  logic [15:0] mode_tab [7] = '{16'h0008, 16'h0048, 16'h0088, 16'h00c8, 16'h0068, 16'h0058, 16'h0078};
  logic [10:0] len_tab [7]  = '{11'd193, 11'd256, 11'd512, 11'd1024, 11'd256, 11'd256, 11'd256};
  logic [10:0] at_tab [7]   = '{11'd0, 11'd0, 11'd0, 11'd0, 11'd255, 11'd1, 11'd254};

  tpl1_tx_port #(.PORT_NUM(0)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_serial_clock_pin(link_clk), .tx_frame_sync_pin(frame_sync), .rx_line_data_pin(line_data),
    .tx_serial_data_pin(tx_data), .hdlc_tx_data(hdlc_d), .bert_tx_data(bert_d),
    .fast_tx_data(fast_d), .hdlc_bit_take(hdlc_take), .hdlc_channel(hdlc_ch), .bert_bit_take(bert_take),
    .fast_tx_clk(fast_clk), .tx_align_irq(align_irq));

  tpl1_framer_model i_framer (
    .run(run), .frame_len(frame_len), .sync_bit(sync_bit), .line_val(line_val),
    .link_clk(link_clk), .frame_sync(frame_sync), .line_data(line_data));

  // 100 MHz bus clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one single transfer; each phase held until hready is seen high
  task automatic ahb(input logic wr, input logic [7:0] adr, input logic [15:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, adr};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[15:0];
  endtask : ahb

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [15:0] exp);
    ahb(1'b0, adr, 16'h0000);
    chk(name, exp, rd);
  endtask : rd_chk

  // select the entry, then poll busy before anything else touches the store
  task automatic ind(input logic dir, input logic [1:0] tgt, input logic [6:0] slot);
    ahb(1'b1, TPL1_OFS_SEL, {1'b0, dir, 4'h0, tgt, 1'b0, slot});
    rd = 16'hffff;
    while (rd[15] !== 1'b0) ahb(1'b0, TPL1_OFS_SEL, 16'h0000);
  endtask : ind

  task automatic wait_bits(input int n);
    repeat (n) @(posedge link_clk);
    @(posedge hclk);
  endtask : wait_bits

  // low for longer than one link period so the framer restarts its count
  task automatic stop_link();
    run <= 1'b0;
    repeat (20) @(posedge hclk);
  endtask : stop_link

  task automatic end_of_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // a hang counts as a failure
  initial begin
    #800000;
    bad_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {run, line_val, hdlc_d, bert_d, fast_d} = '0;
    frame_len = 11'd256;
    sync_bit = 11'd0;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("ctrl_reset", TPL1_OFS_CTRL, 16'h0000);
    rd_chk("sel_reset", TPL1_OFS_SEL, 16'h0000);
    rd_chk("data_reset", TPL1_OFS_DATA, 16'h0000);
    ahb(1'b1, 8'h0c, 16'hffff);
    rd_chk("unmapped", 8'h0c, 16'h0000);
    ahb(1'b1, TPL1_OFS_CTRL, 16'hffff);
    rd_chk("ctrl_rw", TPL1_OFS_CTRL, 16'h4fff);
    // each of the three legal targets at the top t1 slot, written then read back
    ahb(1'b1, TPL1_OFS_CTRL, 16'h0008);
    for (int t = 0; t < 3; t++) begin
      ahb(1'b1, TPL1_OFS_DATA, 16'ha5c0 + 16'(t));
      ind(1'b0, 2'(t), 7'd23);
    end
    for (int t = 0; t < 3; t++) begin
      ahb(1'b1, TPL1_OFS_DATA, 16'h0000);
      ind(1'b1, 2'(t), 7'd23);
      rd_chk("entry", TPL1_OFS_DATA, 16'ha5c0 + 16'(t));
    end
    rd_chk("sel_rd", TPL1_OFS_SEL, 16'h4217);
    ind(1'b1, 2'h2, 7'd24);
    rd_chk("over_t1", TPL1_OFS_DATA, 16'ha5c2);
    ind(1'b1, 2'h3, 7'd0);
    rd_chk("tgt_bad", TPL1_OFS_DATA, 16'ha5c2);
    ahb(1'b1, TPL1_OFS_CTRL, 16'h00c8);
    ahb(1'b1, TPL1_OFS_DATA, 16'h7f7f);
    ind(1'b0, 2'h1, 7'h7f);
    ahb(1'b1, TPL1_OFS_DATA, 16'h0000);
    ind(1'b1, 2'h1, 7'h7f);
    rd_chk("slot_top", TPL1_OFS_DATA, 16'h7f7f);
    ahb(1'b1, TPL1_OFS_CTRL, 16'h0208);
    ind(1'b1, 2'h1, 7'd1);
    rd_chk("clear_slot", TPL1_OFS_DATA, 16'h7f7f);
    ahb(1'b1, TPL1_OFS_DATA, 16'h8033);
    ind(1'b0, 2'h2, 7'd0);
    // source selection in clear-channel mode, misplaced syncs meanwhile
    sync_bit <= 11'd100;
    run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      {hdlc_d, bert_d, fast_d, line_val} <= src_tab[i][7:4];
      ahb(1'b1, TPL1_OFS_CTRL, ctl_tab[i]);
      // let pulses of the previous setting drain before collecting
      repeat (4) @(posedge hclk);
      seen = 3'h0;
      repeat (36) begin
        @(posedge hclk);
        seen = seen | {hdlc_take, bert_take, fast_clk};
      end
      chk("tx_data", {15'h0000, src_tab[i][3]}, {15'h0000, tx_data});
      chk("sources", {13'h0000, src_tab[i][2:0]}, {13'h0000, seen});
    end
    wait_bits(300);
    chk("channel", 16'h0033, {8'h00, hdlc_ch});
    rd_chk("clear_no_flag", TPL1_OFS_CTRL, 16'h0a00);
    stop_link();
    // every frame length, and each of the three early sync offsets, must stay aligned
    for (int i = 0; i < 7; i++) begin
      frame_len <= len_tab[i];
      sync_bit <= at_tab[i];
      ahb(1'b1, TPL1_OFS_CTRL, mode_tab[i]);
      run <= 1'b1;
      wait_bits(at_tab[i] + 4);
      ahb(1'b0, TPL1_OFS_CTRL, 16'h0000);
      wait_bits(len_tab[i] + 4);
      stop_link();
      rd_chk("aligned", TPL1_OFS_CTRL, mode_tab[i]);
    end
    // e1 frames against t1 mode raise the flag; mask gates the interrupt
    frame_len <= 11'd256;
    sync_bit <= 11'd0;
    ahb(1'b1, TPL1_OFS_CTRL, 16'h4008);
    run <= 1'b1;
    wait_bits(300);
    stop_link();
    chk("irq_on", 16'h0001, {15'h0000, align_irq});
    ahb(1'b1, TPL1_OFS_CTRL, 16'h0008);
    @(posedge hclk);
    chk("irq_off", 16'h0000, {15'h0000, align_irq});
    rd_chk("flag_set", TPL1_OFS_CTRL, 16'h8008);
    rd_chk("flag_clr", TPL1_OFS_CTRL, 16'h0008);
    end_of_test();
  end
endmodule : tb_tpl1_tx_port
